// >>> hdl/lcdc_map.svh
/*
 * Register map, field positions and arithmetic constants of the display
 * controller. Assumes the includer works in the SFR page given below.
 */
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH

// ****************************************
// register page and offsets
// ****************************************
`define LCDC_PAGE 8'h06
`define LCDC_A_CTL 8'h98
`define LCDC_A_CLK 8'h99
`define LCDC_A_DMA 8'h9A
`define LCDC_A_SRCH 8'h9B
`define LCDC_A_SRCL 8'h9C
`define LCDC_A_CCH 8'h9D
`define LCDC_A_CCL 8'h9E
`define LCDC_A_RMAX 8'h9F
`define LCDC_A_EXTL 8'h96
`define LCDC_A_EXTH 8'h97

// ****************************************
// field positions
// ****************************************
`define LCDC_B_START 5
`define LCDC_B_CDSEL 4
`define LCDC_B_FRST 3
`define LCDC_B_SWAP 2
`define LCDC_B_BUS16 1
`define LCDC_B_CNV 0
`define LCDC_B_HTCPD 5
`define LCDC_B_DONE 4
`define LCDC_B_MODE 3
`define LCDC_B_HTCIE 2
`define LCDC_B_TCIE 1
`define LCDC_B_TRANS 0

// ****************************************
// address and colour arithmetic
// ****************************************
`define LCDC_CHROMA_OFS (16'h0140 * 16'h0010)
`define LCDC_K_RCR 20'sh00167
`define LCDC_K_GCB 20'sh00058
`define LCDC_K_GCR 20'sh000B7
`define LCDC_K_BCB 20'sh001C6
`define LCDC_MID 20'sh00080

`endif

// >>> hdl/lcdc_pkg.sv
/*
 * Types shared by the display controller: state enumerations.
 * Assumes nothing of its surroundings.
 */
package lcdc_pkg;

  typedef enum logic [2:0] {
    D_OFF, D_IDLE, D_ISSUE, D_READ, D_CAPT, D_PUSH, D_DRAIN
  } lcdc_dma_state_t;

  typedef enum logic [1:0] {
    T_IDLE, T_LOW, T_HIGH
  } lcdc_tg_state_t;

endpackage : lcdc_pkg

// >>> hdl/lcdc_top.sv
/*
 * Parallel LCD controller with its own display DMA engine, colour
 * converter, byte FIFO and write-strobe timing generator.
 * Assumes a synchronous byte RAM that returns data one cycle after its
 * read enable is sampled low, and SFR signals synchronous to core_clk.
 */
`timescale 1ns/10ps
`include "lcdc_map.svh"

module lcdc_top #(
  parameter int FIFO_AW = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic lcd_irq,
  output logic [15:0] dma_mem_address,
  output logic dma_mem_read_n,
  input wire logic [7:0] dma_mem_read_data,
  output logic fifo_refill_request,
  output logic lcm_chip_select_n,
  output logic lcm_cmd_data_sel,
  output logic lcm_write_n,
  output logic [15:0] lcm_data,
  output logic ext_wr_stb,
  output logic ext_rd_stb,
  output logic ext_wide,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] ext_rdata
);

  localparam int FIFO_DEPTH = 2 ** FIFO_AW;
  localparam logic [FIFO_AW:0] HALF = (FIFO_AW + 1)'(FIFO_DEPTH / 2);

  typedef struct packed {
    logic start_en;
    logic cd_sel;
    logic fifo_rst;
    logic rgb_swap;
    logic bus16;
    logic cconv;
    logic [3:0] hdiv;
    logic [3:0] ldiv;
    logic [1:0] clkdiv;
    logic htcpd;
    logic dpend;
    logic mode;
    logic htc_ie;
    logic tc_ie;
    logic trans;
    logic [15:0] src;
    logic [8:0] ccnt;
    logic [7:0] rmax;
    logic start_prev;
    lcdc_pkg::lcdc_dma_state_t dst;
    logic [1:0] bidx;
    logic [3:0][7:0] tmp;
    logic [8:0] col;
    logic [7:0] row;
    logic [15:0] lin;
    logic [15:0] lrow;
    logic [15:0] crow;
    logic last;
    logic [15:0] maddr;
    logic mrd_n;
    logic [FIFO_DEPTH-1:0][7:0] fmem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0] fcnt;
    lcdc_pkg::lcdc_tg_state_t tst;
    logic [3:0] tcnt;
    logic cs_n;
    logic wr_n;
    logic cd;
    logic [15:0] pdata;
    logic req;
    logic irq;
    logic [7:0] rdata;
    logic ext_armed;
    logic ext_rarmed;
    logic [7:0] ext_lo;
    logic [7:0] ext_rlo;
    logic ext_wr;
    logic ext_rd;
    logic ext_w16;
    logic [15:0] ext_wd;
  } lcdc_state_t;

  lcdc_state_t r_reg;
  lcdc_state_t r_next;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic lcdc_hit(input logic [7:0] pg,
                                    input logic [7:0] ad,
                                    input logic [7:0] tgt);
    lcdc_hit = (pg == `LCDC_PAGE) && (ad == tgt);
  endfunction : lcdc_hit

  function automatic logic [7:0] lcdc_clamp(input logic signed [19:0] v);
    if (v < 20'sh00000) begin
      lcdc_clamp = 8'h00;
    end else if (v[19:16] != 4'h0) begin
      lcdc_clamp = 8'hFF;
    end else begin
      lcdc_clamp = v[15:8];
    end
  endfunction : lcdc_clamp

  // coefficients carry eight fraction bits; rounding error stays below
  // one RGB888 step, which truncation to RGB565 hides anyway
  function automatic logic [15:0] lcdc_ycc565(input logic [7:0] y,
                                              input logic [7:0] cb,
                                              input logic [7:0] cr,
                                              input logic swap);
    logic signed [19:0] yy;
    logic signed [19:0] db;
    logic signed [19:0] dr;
    logic [7:0] r8;
    logic [7:0] g8;
    logic [7:0] b8;
    yy = $signed({4'h0, y, 8'h00});
    db = $signed({12'h000, cb}) - `LCDC_MID;
    dr = $signed({12'h000, cr}) - `LCDC_MID;
    r8 = lcdc_clamp(yy + dr * `LCDC_K_RCR);
    g8 = lcdc_clamp(yy - db * `LCDC_K_GCB - dr * `LCDC_K_GCR);
    b8 = lcdc_clamp(yy + db * `LCDC_K_BCB);
    if (swap) begin
      lcdc_ycc565 = {b8[7:3], g8[7:2], r8[7:3]};
    end else begin
      lcdc_ycc565 = {r8[7:3], g8[7:2], b8[7:3]};
    end
  endfunction : lcdc_ycc565

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [15:0] ofs;
    logic [15:0] width;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [3:0][7:0] pb;
    logic [FIFO_AW:0] need;
    logic [FIFO_AW:0] npop;
    logic push;
    logic launch;
    ofs = 16'h0000;
    width = 16'h0000;
    p1 = 16'h0000;
    p2 = 16'h0000;
    pb = '0;
    need = '0;
    npop = '0;
    push = 1'b0;
    launch = 1'b0;
    r_next = r_reg;
    r_next.ext_wr = 1'b0;
    r_next.ext_rd = 1'b0;

    // register writes; pending flags clear on a written one
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_CTL)) begin
      r_next.start_en = sfr_wdata[`LCDC_B_START];
      r_next.cd_sel = sfr_wdata[`LCDC_B_CDSEL];
      r_next.fifo_rst = sfr_wdata[`LCDC_B_FRST];
      r_next.rgb_swap = sfr_wdata[`LCDC_B_SWAP];
      r_next.bus16 = sfr_wdata[`LCDC_B_BUS16];
      r_next.cconv = sfr_wdata[`LCDC_B_CNV];
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_CLK)) begin
      r_next.hdiv = sfr_wdata[7:4];
      r_next.ldiv = sfr_wdata[3:0];
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_DMA)) begin
      r_next.clkdiv = sfr_wdata[7:6];
      r_next.htcpd = r_reg.htcpd & ~sfr_wdata[`LCDC_B_HTCPD];
      r_next.dpend = r_reg.dpend & ~sfr_wdata[`LCDC_B_DONE];
      r_next.mode = sfr_wdata[`LCDC_B_MODE];
      r_next.htc_ie = sfr_wdata[`LCDC_B_HTCIE];
      r_next.tc_ie = sfr_wdata[`LCDC_B_TCIE];
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_SRCH)) begin
      r_next.src[15:8] = sfr_wdata;
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_SRCL)) begin
      r_next.src[7:0] = sfr_wdata;
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_CCH)) begin
      r_next.ccnt[8] = sfr_wdata[0];
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_CCL)) begin
      r_next.ccnt[7:0] = sfr_wdata;
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_RMAX)) begin
      r_next.rmax = sfr_wdata;
    end

    // extended bus: each low write is a byte access, a high write after a low one a word
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_EXTL)) begin
      r_next.ext_wr = 1'b1;
      r_next.ext_w16 = 1'b0;
      r_next.ext_wd = {8'h00, sfr_wdata};
      r_next.ext_lo = sfr_wdata;
      r_next.ext_armed = 1'b1;
    end
    if (sfr_we && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_EXTH) &&
        r_reg.ext_armed) begin
      r_next.ext_wr = 1'b1;
      r_next.ext_w16 = 1'b1;
      r_next.ext_wd = {sfr_wdata, r_reg.ext_lo};
      r_next.ext_armed = 1'b0;
    end

    // read data
    r_next.rdata = 8'h00;
    if (sfr_page == `LCDC_PAGE) begin
      case (sfr_addr)
        `LCDC_A_CTL: r_next.rdata = {2'b00, r_reg.start_en, r_reg.cd_sel,
          r_reg.fifo_rst, r_reg.rgb_swap, r_reg.bus16, r_reg.cconv};
        `LCDC_A_CLK: r_next.rdata = {r_reg.hdiv, r_reg.ldiv};
        `LCDC_A_DMA: r_next.rdata = {r_reg.clkdiv, r_reg.htcpd, r_reg.dpend,
          r_reg.mode, r_reg.htc_ie, r_reg.tc_ie, r_reg.trans};
        `LCDC_A_SRCH: r_next.rdata = r_reg.src[15:8];
        `LCDC_A_SRCL: r_next.rdata = r_reg.src[7:0];
        `LCDC_A_CCH: r_next.rdata = {7'h00, r_reg.ccnt[8]};
        `LCDC_A_CCL: r_next.rdata = r_reg.ccnt[7:0];
        `LCDC_A_RMAX: r_next.rdata = r_reg.rmax;
        default: r_next.rdata = 8'h00;
      endcase
    end
    if (sfr_re && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_EXTH)) begin
      r_next.ext_rd = 1'b1;
      r_next.ext_w16 = 1'b1;
      r_next.rdata = ext_rdata[15:8];
      r_next.ext_rlo = ext_rdata[7:0];
      r_next.ext_rarmed = 1'b1;
    end else if (sfr_re && lcdc_hit(sfr_page, sfr_addr, `LCDC_A_EXTL)) begin
      if (r_reg.ext_rarmed) begin
        r_next.rdata = r_reg.ext_rlo;
        r_next.ext_rarmed = 1'b0;
      end else begin
        r_next.ext_rd = 1'b1;
        r_next.ext_w16 = 1'b0;
        r_next.rdata = ext_rdata[7:0];
      end
    end

    // ****************************************
    // display DMA engine
    // ****************************************
    ofs = {7'h00, r_reg.col} + {15'h0000, r_reg.bidx[0]};
    width = {7'h00, r_reg.ccnt} + 16'h0001;
    case (r_reg.dst)
      lcdc_pkg::D_OFF: begin
      end
      lcdc_pkg::D_IDLE: begin
        if (r_reg.last) begin
          r_next.dst = lcdc_pkg::D_DRAIN;
        end else if (r_reg.fcnt <= HALF && !r_reg.fifo_rst) begin
          r_next.dst = lcdc_pkg::D_ISSUE;
        end
      end
      lcdc_pkg::D_ISSUE: begin
        if (r_reg.mode) begin
          // luma pair first, then the shared chroma pair
          r_next.maddr = (r_reg.bidx[1] ? r_reg.crow : r_reg.lrow) + ofs;
        end else begin
          r_next.maddr = r_reg.lin;
        end
        r_next.mrd_n = 1'b0;
        r_next.dst = lcdc_pkg::D_READ;
      end
      lcdc_pkg::D_READ: begin
        r_next.mrd_n = 1'b1;
        r_next.dst = lcdc_pkg::D_CAPT;
      end
      lcdc_pkg::D_CAPT: begin
        r_next.tmp[r_reg.bidx] = dma_mem_read_data;
        r_next.lin = r_reg.lin + 16'h0001;
        r_next.bidx = r_reg.bidx + 2'h1;
        r_next.dst = (r_reg.bidx == 2'h3) ? lcdc_pkg::D_PUSH
                                          : lcdc_pkg::D_ISSUE;
      end
      lcdc_pkg::D_PUSH: begin
        push = 1'b1;
        if ({7'h00, r_reg.col} + 16'h0001 >= {7'h00, r_reg.ccnt}) begin
          r_next.col = 9'h000;
          r_next.lrow = r_reg.lrow + width;
          if (r_reg.row[0]) begin
            r_next.crow = r_reg.crow + width;
          end
          r_next.row = r_reg.row + 8'h01;
          if (r_reg.row == r_reg.rmax) begin
            r_next.last = 1'b1;
          end
        end else begin
          r_next.col = r_reg.col + 9'h002;
        end
        r_next.dst = lcdc_pkg::D_IDLE;
      end
      lcdc_pkg::D_DRAIN: begin
        if (r_reg.fcnt == 0 && r_reg.tst == lcdc_pkg::T_IDLE) begin
          r_next.trans = 1'b1;
          r_next.dpend = 1'b1;
          r_next.dst = lcdc_pkg::D_OFF;
        end
      end
      default: r_next.dst = lcdc_pkg::D_OFF;
    endcase

    // a new rising edge restarts the engine from the programmed values
    if (r_reg.start_en && !r_reg.start_prev) begin
      r_next.trans = 1'b0;
      r_next.col = 9'h000;
      r_next.row = 8'h00;
      r_next.lin = r_reg.src;
      r_next.lrow = r_reg.src;
      r_next.crow = r_reg.src + `LCDC_CHROMA_OFS;
      r_next.bidx = 2'h0;
      r_next.last = 1'b0;
      // a restart during a fetch must not leave the read enable low
      r_next.mrd_n = 1'b1;
      r_next.dst = lcdc_pkg::D_IDLE;
    end
    r_next.start_prev = r_reg.start_en;

    // ****************************************
    // converter or bypass into the FIFO
    // ****************************************
    p1 = lcdc_ycc565(r_reg.tmp[0], r_reg.tmp[2], r_reg.tmp[3],
                     r_reg.rgb_swap);
    p2 = lcdc_ycc565(r_reg.tmp[1], r_reg.tmp[2], r_reg.tmp[3],
                     r_reg.rgb_swap);
    if (r_reg.mode && r_reg.cconv) begin
      pb = {p2[7:0], p2[15:8], p1[7:0], p1[15:8]};
    end else begin
      pb = r_reg.tmp;
    end
    if (push) begin
      for (int i = 0; i < 4; i++) begin
        r_next.fmem[r_reg.wp + FIFO_AW'(i)] = pb[i];
      end
      r_next.wp = r_reg.wp + FIFO_AW'(4);
    end

    // ****************************************
    // write-strobe timing generator
    // ****************************************
    need = r_reg.bus16 ? (FIFO_AW + 1)'(2) : (FIFO_AW + 1)'(1);
    case (r_reg.tst)
      lcdc_pkg::T_IDLE: begin
        launch = (r_reg.fcnt >= need);
      end
      lcdc_pkg::T_LOW: begin
        if (r_reg.tcnt == 4'h0) begin
          r_next.wr_n = 1'b1;
          r_next.tcnt = r_reg.hdiv;
          r_next.tst = lcdc_pkg::T_HIGH;
        end else begin
          r_next.tcnt = r_reg.tcnt - 4'h1;
        end
      end
      lcdc_pkg::T_HIGH: begin
        if (r_reg.tcnt != 4'h0) begin
          r_next.tcnt = r_reg.tcnt - 4'h1;
        end else if (r_reg.fcnt >= need && !r_reg.fifo_rst) begin
          launch = 1'b1;
        end else begin
          r_next.cs_n = 1'b1;
          r_next.tst = lcdc_pkg::T_IDLE;
        end
      end
      default: r_next.tst = lcdc_pkg::T_IDLE;
    endcase
    if (launch && !r_reg.fifo_rst) begin
      npop = need;
      if (r_reg.bus16) begin
        r_next.pdata = {r_reg.fmem[r_reg.rp],
                        r_reg.fmem[r_reg.rp + FIFO_AW'(1)]};
      end else begin
        r_next.pdata = {8'h00, r_reg.fmem[r_reg.rp]};
      end
      r_next.cs_n = 1'b0;
      r_next.wr_n = 1'b0;
      r_next.tcnt = r_reg.ldiv;
      r_next.tst = lcdc_pkg::T_LOW;
    end
    r_next.cd = r_reg.cd_sel;
    r_next.rp = r_reg.rp + FIFO_AW'(npop);
    r_next.fcnt = r_reg.fcnt - npop + (push ? (FIFO_AW + 1)'(4)
                                             : (FIFO_AW + 1)'(0));
    if (r_reg.fifo_rst) begin
      r_next.wp = '0;
      r_next.rp = '0;
      r_next.fcnt = '0;
    end

    r_next.req = (r_reg.dst == lcdc_pkg::D_IDLE) && !r_reg.last &&
                 (r_reg.fcnt <= HALF);
    r_next.irq = (r_next.dpend & r_next.tc_ie) |
                 (r_next.htcpd & r_next.htc_ie);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.trans <= 1'b1;
      r_reg.mrd_n <= 1'b1;
      r_reg.cs_n <= 1'b1;
      r_reg.wr_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sfr_rdata = r_reg.rdata;
  assign lcd_irq = r_reg.irq;
  assign dma_mem_address = r_reg.maddr;
  assign dma_mem_read_n = r_reg.mrd_n;
  assign fifo_refill_request = r_reg.req;
  assign lcm_chip_select_n = r_reg.cs_n;
  assign lcm_cmd_data_sel = r_reg.cd;
  assign lcm_write_n = r_reg.wr_n;
  assign lcm_data = r_reg.pdata;
  assign ext_wr_stb = r_reg.ext_wr;
  assign ext_rd_stb = r_reg.ext_rd;
  assign ext_wide = r_reg.ext_w16;
  assign ext_wdata = r_reg.ext_wd;

  // ****************************************
  // checks
  // ****************************************
  default clocking lcdc_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_START_CLEARS_FINISH: assert property (
    $rose(r_reg.start_en) |=> !r_reg.trans && r_reg.dst == lcdc_pkg::D_IDLE)
    else $error("start edge did not restart the engine");
  AST_CD_FOLLOWS: assert property (
    ##1 lcm_cmd_data_sel == $past(r_reg.cd_sel))
    else $error("command/data pin does not follow select bit");
  AST_FIFO_BOUND: assert property (
    r_reg.fcnt <= (FIFO_AW + 1)'(FIFO_DEPTH))
    else $error("fifo level above depth");
  AST_REFILL_REQ: assert property (
    (r_reg.dst == lcdc_pkg::D_IDLE && !r_reg.last && r_reg.fcnt <= HALF)
    |=> fifo_refill_request)
    else $error("refill request missing at half empty");
  AST_BACK_TO_BACK: assert property (
    (r_reg.tst == lcdc_pkg::T_HIGH && r_reg.tcnt == 4'h0 &&
     !r_reg.fifo_rst && r_reg.fcnt >= (r_reg.bus16 ? 2 : 1))
    |=> !lcm_write_n && !lcm_chip_select_n)
    else $error("write cycle not started while data waits");
  AST_FOUR_READS: assert property (
    (r_reg.dst == lcdc_pkg::D_IDLE ##1 r_reg.dst == lcdc_pkg::D_ISSUE)
    |-> ##12 r_reg.dst == lcdc_pkg::D_PUSH ##1
        r_reg.dst == lcdc_pkg::D_IDLE)
    else $error("fetch was not four byte reads");
  AST_SHORT_LOW: assert property (
    ($fell(lcm_write_n) && r_reg.ldiv == 4'h0) |=> lcm_write_n)
    else $error("one-cycle low phase not honoured");
  AST_CS_DURING_WRITE: assert property (
    !lcm_write_n |-> !lcm_chip_select_n)
    else $error("write strobe without chip select");
  AST_BUS8_HIGH_ZERO: assert property (
    ($fell(lcm_write_n) && !r_reg.bus16) |-> lcm_data[15:8] == 8'h00)
    else $error("eight-bit write carried upper byte");
  AST_DONE_FLAG: assert property (
    ($rose(r_reg.dpend) && r_reg.tc_ie) |=> lcd_irq && r_reg.trans)
    else $error("completion did not raise interrupt");

endmodule : lcdc_top

// >>> tb/lcdc_panel_model.sv
/*
 * Behavioural panel on the parallel write bus: records each written word.
 * Assumes the strobe and chip select are synchronous to core_clk.
 */
`timescale 1ns/10ps
module lcdc_panel_model (
  input wire logic core_clk,
  input wire logic lcm_chip_select_n,
  input wire logic lcm_write_n,
  input wire logic [15:0] lcm_data
);
  logic [15:0] words[$];
  int low_len = 0;
  int high_len = 0;
  int run_len = 0;
  int cs_bad = 0;
  logic wr_q = 1'b1;
  logic cs_q = 1'b1;

  // ****************************************
  // strobe phase measurement and capture
  // ****************************************
  always @(posedge core_clk) begin
    if (lcm_write_n === 1'b0 && lcm_chip_select_n !== 1'b0) begin
      cs_bad++;
    end
    if (lcm_write_n !== wr_q) begin
      if (wr_q === 1'b0) begin
        low_len = run_len;
        // the panel latches data on the strobe's rising edge
        words.push_back(lcm_data);
      end else if (cs_q === 1'b0) begin
        // only a high phase between two writes counts
        high_len = run_len;
      end
      run_len = 1;
    end else begin
      run_len++;
    end
    wr_q = lcm_write_n;
    cs_q = lcm_chip_select_n;
  end
endmodule : lcdc_panel_model

// >>> tb/tb_lcd_parallel_controller_dma.sv
/*
 * Self-checking bench: SFR accesses, DMA transfers to the panel model.
 * Assumes the byte RAM answers one cycle after its read strobe.
 */
`timescale 1ns/10ps
`include "lcdc_map.svh"
module tb_lcd_parallel_controller_dma;
  logic core_clk, rst_n, sfr_we, sfr_re;
  logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata, dma_mem_read_data;
  logic lcd_irq, dma_mem_read_n, fifo_refill_request;
  logic lcm_chip_select_n, lcm_cmd_data_sel, lcm_write_n;
  logic ext_wr_stb, ext_rd_stb, ext_wide;
  logic [15:0] dma_mem_address, lcm_data, ext_wdata, ext_rdata;
  logic [16:0] ext_seen;
  logic [7:0] d;
  logic [7:0] y;
  logic [16:0] xr;
  logic req_seen = 1'b0;
  int err_count = 0;
  int checks_done = 0;

  lcdc_top #(.FIFO_AW(3)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .lcd_irq(lcd_irq), .dma_mem_address(dma_mem_address),
    .dma_mem_read_n(dma_mem_read_n), .dma_mem_read_data(dma_mem_read_data),
    .fifo_refill_request(fifo_refill_request),
    .lcm_chip_select_n(lcm_chip_select_n),
    .lcm_cmd_data_sel(lcm_cmd_data_sel), .lcm_write_n(lcm_write_n),
    .lcm_data(lcm_data), .ext_wr_stb(ext_wr_stb), .ext_rd_stb(ext_rd_stb),
    .ext_wide(ext_wide), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  lcdc_panel_model PANEL (.core_clk(core_clk),
    .lcm_chip_select_n(lcm_chip_select_n), .lcm_write_n(lcm_write_n),
    .lcm_data(lcm_data));

  // ****************************************
  // clock, byte RAM, extended bus monitor
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // chroma plane holds mid-grey so a wrong chroma address shows
  function automatic logic [7:0] mem_f(input logic [15:0] a);
    return (a >= 16'h1400) ? 8'h80 : (a[7:0] ^ 8'h5A);
  endfunction : mem_f

  always @(negedge core_clk) begin
    if (dma_mem_read_n === 1'b0) begin
      dma_mem_read_data <= mem_f(dma_mem_address);
    end
  end

  always @(posedge core_clk) begin
    if (ext_wr_stb === 1'b1) begin
      ext_seen <= {ext_wide, ext_wdata};
    end
    if (fifo_refill_request === 1'b1) begin
      req_seen <= 1'b1;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_we = 1'b1;
    @(negedge core_clk);
    sfr_we = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    sfr_addr = a;
    @(negedge core_clk);
    v = sfr_rdata;
  endtask : sfr_rd

  // one-edge read strobe; returns {read strobe, wide, data}
  task automatic sfr_xrd(input logic [7:0] a, output logic [16:0] v);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge core_clk);
    sfr_re = 1'b0;
    v = {7'h00, ext_rd_stb, ext_wide, sfr_rdata};
  endtask : sfr_xrd

  // start bit written low, then high, so a rising edge is always seen
  task automatic run_xfer(input logic [7:0] ctl, input logic [7:0] dmac);
    PANEL.words.delete();
    sfr_wr(`LCDC_A_CTL, ctl);
    sfr_wr(`LCDC_A_DMA, dmac);
    sfr_wr(`LCDC_A_CTL, ctl | 8'h20);
    for (int k = 0; k < 3000; k++) begin
      sfr_rd(`LCDC_A_DMA, d);
      if (d[0] === 1'b1) begin
        return;
      end
    end
    err_count++;
    complete_run();
  endtask : run_xfer

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    sfr_page = `LCDC_PAGE;
    sfr_addr = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    sfr_wdata = 8'h00;
    dma_mem_read_data = 8'h00;
    ext_rdata = 16'hC3A5;
    ext_seen = 17'h00000;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    for (int a = 8'h98; a <= 8'h9F; a++) begin
      sfr_rd(8'(a), d);
      check({9'h000, d}, (a == 8'h9A) ? 17'h00001 : 17'h00000);
    end
    sfr_wr(`LCDC_A_CCH, 8'hFF);
    sfr_rd(`LCDC_A_CCH, d);
    check({9'h000, d}, 17'h00001);
    sfr_wr(`LCDC_A_CLK, 8'h21);
    sfr_rd(`LCDC_A_CLK, d);
    check({9'h000, d}, 17'h00021);
    for (int s = 1; s >= 0; s--) begin
      sfr_wr(`LCDC_A_CTL, s ? 8'h10 : 8'h00);
      @(negedge core_clk);
      check({16'h0000, lcm_cmd_data_sel}, 17'(s));
    end
    sfr_wr(`LCDC_A_SRCH, 8'h00);
    sfr_wr(`LCDC_A_SRCL, 8'h10);
    sfr_wr(`LCDC_A_CCH, 8'h00);
    sfr_wr(`LCDC_A_CCL, 8'h01);
    sfr_wr(`LCDC_A_RMAX, 8'h01);
    // 2 x 2 pixels, eight-bit bus: one byte per strobe
    run_xfer(8'h00, 8'h02);
    check(17'(PANEL.words.size()), 17'h00008);
    for (int i = 0; i < 8; i++) begin
      check({1'b0, PANEL.words[i]}, {9'h000, mem_f(16'h0010 + 16'(i))});
    end
    check({9'h000, d}, 17'h00013);
    @(negedge core_clk);
    check({16'h0000, lcd_irq}, 17'h00001);
    check({16'h0000, lcm_chip_select_n}, 17'h00001);
    check(17'(PANEL.cs_bad), 17'h00000);
    check(17'(PANEL.low_len), 17'h00002);
    check(17'(PANEL.high_len), 17'h00003);
    check({16'h0000, req_seen}, 17'h00001);
    check({16'h0000, fifo_refill_request}, 17'h00000);
    sfr_wr(`LCDC_A_DMA, 8'h12);
    sfr_rd(`LCDC_A_DMA, d);
    check({9'h000, d}, 17'h00003);
    check({16'h0000, lcd_irq}, 17'h00000);
    // sixteen-bit bus: first byte on the upper half
    run_xfer(8'h02, 8'h00);
    check(17'(PANEL.words.size()), 17'h00004);
    for (int i = 0; i < 4; i++) begin
      check({1'b0, PANEL.words[i]}, {1'b0, mem_f(16'h0010 + 16'(2 * i)),
        mem_f(16'h0011 + 16'(2 * i))});
    end
    // grey chroma turns each luma byte into an equal-channel pixel
    sfr_wr(`LCDC_A_SRCL, 8'h00);
    sfr_wr(`LCDC_A_RMAX, 8'h00);
    run_xfer(8'h03, 8'h08);
    check(17'(PANEL.words.size()), 17'h00002);
    for (int i = 0; i < 2; i++) begin
      y = mem_f(16'(i));
      check({1'b0, PANEL.words[i]}, {1'b0, y[7:3], y[7:2], y[7:3]});
    end
    sfr_wr(`LCDC_A_EXTL, 8'h34);
    @(negedge core_clk);
    check(ext_seen, 17'h00034);
    sfr_wr(`LCDC_A_EXTH, 8'h12);
    @(negedge core_clk);
    check(ext_seen, 17'h11234);
    // high read latches the low byte; the next low read returns it
    sfr_xrd(`LCDC_A_EXTH, xr);
    check(xr, 17'h003C3);
    ext_rdata = 16'h5A3C;
    sfr_xrd(`LCDC_A_EXTL, xr);
    check(xr, 17'h001A5);
    sfr_xrd(`LCDC_A_EXTL, xr);
    check(xr, 17'h0023C);
    complete_run();
  end
endmodule : tb_lcd_parallel_controller_dma
